// ===== half_bridge_pkg.sv
// constants and types shared by the half-bridge input control logic
package half_bridge_pkg;

  // ==========================================================
  // timing
  localparam int CLK_KHZ      = 25000;
  localparam int TOFF_US      = 30;
  localparam int TOFF_CYC     = TOFF_US * CLK_KHZ / 1000;
  localparam int SSC_KHZ      = 1300;
  localparam int SSC_PCT      = 12;
  localparam int SSC_HALF_CYC = CLK_KHZ / (2 * SSC_KHZ);
  localparam int SSC_STEP     = (2 * SSC_PCT + SSC_HALF_CYC - 1) / SSC_HALF_CYC;

  // ==========================================================
  // register offsets
  localparam logic [7:0] CMD_OFS     = 8'h00;
  localparam logic [7:0] PIN_CTL_OFS = 8'h04;
  localparam logic [7:0] COMBINE_OFS = 8'h08;
  localparam logic [7:0] SHAPING_OFS = 8'h0c;
  localparam logic [7:0] STATUS_OFS  = 8'h10;

  // ==========================================================
  // field positions and keys
  localparam logic [7:0] UNLOCK_KEY   = 8'h5a;
  localparam int         DIS_BIT      = 0;
  localparam int         LVL_BIT      = 1;
  localparam int         SLEW_LSB     = 0;
  localparam int         SPREAD_BIT   = 3;
  localparam int         TRIP_LSB     = 4;

  // ==========================================================
  // reset values and the hardwired slew pin limit
  localparam logic [1:0] PIN_CTL_RST  = 2'h0;
  localparam logic [1:0] COMBINE_RST  = 2'h0;
  localparam logic [6:0] SHAPING_RST  = 7'h00;
  localparam logic [2:0] SLEW_RST     = 3'h0;
  localparam logic [2:0] SLEW_PIN_MAX = 3'h5;
  localparam logic [9:0] TOFF_RST     = 10'h000;
  localparam logic signed [5:0] SSC_RST = 6'sh00;

  // ==========================================================
  // types
  typedef enum logic [2:0]
  {
    ST_SLEEP   = 3'b001,
    ST_STANDBY = 3'b010,
    ST_ACTIVE  = 3'b100
  } dev_state_t;

  typedef struct packed
  {
    logic       serial_variant;
    logic       ext_logic_supply;
    logic       sleep_request_low;
    logic       output_disable;
    logic       drive_level;
    logic       logic_supply_ok;
    logic       trip_compare;
    logic       high_side_on;
    logic       trip_pin_enable;
    logic [2:0] slew_setting_pin;
  } pin_in_t;

  typedef struct packed
  {
    logic [23:0] zero;
    logic        init_pending;
    logic        serial_variant;
    logic        mirror_active;
    logic        toff_active;
    logic        unlocked;
    dev_state_t  state;
  } status_t;

endpackage

// ===== half_bridge_input_control.sv
// input decode, pin/register combine, slew, trip off-time and spread clocking for a half bridge
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns

module half_bridge_input_control
  import half_bridge_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // device pins and straps
  input  wire pin_in_t     pins,
  // bridge and analog control
  output dev_state_t       device_state,
  output logic             bridge_drive_en,
  output logic             bridge_level,
  output logic             offstate_diag_en,
  output logic             current_mirror_output,
  output logic      [2:0]  slew_select,
  output logic signed [5:0] spread_offset
);

  // ==========================================================
  // declarations
  pin_in_t          pin_meta_r;
  pin_in_t          pin_s;
  logic             unlocked_r;
  logic [1:0]       pin_ctl_r;
  logic [1:0]       combine_r;
  logic [6:0]       shaping_r;
  logic [2:0]       slew_hw_r;
  logic             init_pending_r;
  logic [9:0]       toff_cnt_r;
  logic [9:0]       toff_nxt;
  logic             dis_prev_r;
  logic             lvl_prev_r;
  logic             spread_up_r;
  logic signed [5:0] spread_nxt;
  logic             spread_up_nxt;
  dev_state_t       state_r;
  dev_state_t       state_nxt;
  logic             drive_en_r;
  logic             level_r;
  logic             diag_r;
  logic             mirror_r;
  logic [2:0]       slew_r;
  logic signed [5:0] spread_r;
  logic [31:0]      prdata_r;
  logic             pready_r;
  logic             pslverr_r;
  status_t          status;

  // ==========================================================
  // pin synchroniser
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      pin_meta_r <= '0;
      pin_s      <= '0;
    end
    else
    begin
      pin_meta_r <= pins;
      pin_s      <= pin_meta_r;
    end
  end

  // ==========================================================
  // apb decode
  wire setup_phase = psel && !penable;
  wire access_ok   = psel && penable && pready_r;
  wire wr_en       = access_ok && pwrite;
  wire hit_cmd     = paddr == CMD_OFS;
  wire hit_pin     = paddr == PIN_CTL_OFS;
  wire hit_comb    = paddr == COMBINE_OFS;
  wire hit_shape   = paddr == SHAPING_OFS;
  wire hit_stat    = paddr == STATUS_OFS;
  wire mapped      = hit_cmd || hit_pin || hit_comb || hit_shape || hit_stat;
  wire wr_cmd      = wr_en && hit_cmd;
  wire wr_pin      = wr_en && hit_pin;
  wire wr_comb     = wr_en && hit_comb;
  wire wr_shape    = wr_en && hit_shape;

  assign status = '{zero: 24'h000000, init_pending: init_pending_r, serial_variant: pin_s.serial_variant,
                    mirror_active: mirror_r, toff_active: toff_cnt_r != TOFF_RST, unlocked: unlocked_r,
                    state: state_r};

  wire [31:0] rd_data = hit_pin   ? {30'h00000000, pin_ctl_r} :
                        hit_comb  ? {30'h00000000, combine_r} :
                        hit_shape ? {25'h0000000, shaping_r} :
                        hit_stat  ? 32'(status) : 32'h00000000;

  // ==========================================================
  // register file
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      unlocked_r <= 1'b0;
      pin_ctl_r  <= PIN_CTL_RST;
      combine_r  <= COMBINE_RST;
      shaping_r  <= SHAPING_RST;
      prdata_r   <= 32'h00000000;
      pready_r   <= 1'b0;
      pslverr_r  <= 1'b0;
    end
    else
    begin
      if (wr_cmd)
        unlocked_r <= pwdata[7:0] == UNLOCK_KEY;
      if (wr_pin)
        pin_ctl_r <= pwdata[1:0];
      if (wr_comb)
        combine_r <= pwdata[1:0];
      if (wr_shape)
        shaping_r <= pwdata[6:0];
      if (setup_phase && !pwrite)
        prdata_r <= rd_data;
      pready_r  <= setup_phase;
      pslverr_r <= setup_phase && !mapped;
    end
  end

  // ==========================================================
  // input combine
  wire ext_mode   = pin_s.serial_variant && pin_s.ext_logic_supply;
  wire sleep_eff  = ext_mode ? 1'b1 : pin_s.sleep_request_low;
  wire powered    = !ext_mode || pin_s.logic_supply_ok;
  wire sel_dis    = combine_r[DIS_BIT];
  wire sel_lvl    = combine_r[LVL_BIT];
  wire reg_output_disable = pin_ctl_r[DIS_BIT];
  wire reg_drive_level    = pin_ctl_r[LVL_BIT];
  wire dis_comb   = sel_dis ? (pin_s.output_disable & reg_output_disable)
                            : (pin_s.output_disable | reg_output_disable);
  wire lvl_comb   = sel_lvl ? (pin_s.drive_level & reg_drive_level)
                            : (pin_s.drive_level | reg_drive_level);
  wire use_regs   = unlocked_r && pin_s.serial_variant;
  wire dis_eff    = use_regs ? dis_comb : pin_s.output_disable;
  wire level_eff  = use_regs ? lvl_comb : pin_s.drive_level;
  wire in_change  = (dis_eff != dis_prev_r) || (level_eff != lvl_prev_r);

  // ==========================================================
  // state decode and trip off-time
  assign state_nxt = (!sleep_eff || !powered) ? ST_SLEEP :
                     dis_eff ? ST_STANDBY : ST_ACTIVE;

  wire trip_field  = shaping_r[TRIP_LSB +: 3] != 3'h0;
  wire trip_en     = pin_s.serial_variant ? trip_field : pin_s.trip_pin_enable;
  wire toff_active = toff_cnt_r != TOFF_RST;
  wire next_active = state_nxt == ST_ACTIVE;
  wire trip_start  = trip_en && pin_s.trip_compare && drive_en_r && level_r && !toff_active &&
                     !in_change && next_active && level_eff;

  assign toff_nxt = (in_change || !next_active) ? TOFF_RST :
                    trip_start ? 10'(TOFF_CYC) :
                    toff_active ? toff_cnt_r - 10'h001 : TOFF_RST;

  wire level_nxt  = next_active && level_eff && toff_nxt == TOFF_RST;
  wire diag_nxt   = state_nxt == ST_STANDBY && level_eff;
  wire mirror_nxt = level_nxt && pin_s.high_side_on;

  // ==========================================================
  // slew setting
  wire [2:0] slew_pin_lvl = pin_s.slew_setting_pin > SLEW_PIN_MAX ? SLEW_PIN_MAX : pin_s.slew_setting_pin;
  wire       capture_slew = init_pending_r && state_nxt != ST_SLEEP;
  wire [2:0] slew_nxt     = pin_s.serial_variant ? shaping_r[SLEW_LSB +: 3] : slew_hw_r;

  // ==========================================================
  // spread clocking triangle
  localparam logic signed [5:0] SSC_TOP  = 6'(SSC_PCT);
  localparam logic signed [5:0] SSC_INC  = 6'(SSC_STEP);
  wire spread_on = pin_s.serial_variant && shaping_r[SPREAD_BIT];
  wire signed [5:0] spread_step = spread_up_r ? spread_r + SSC_INC : spread_r - SSC_INC;
  assign spread_nxt    = spread_on ? spread_step : SSC_RST;
  assign spread_up_nxt = !spread_on ? 1'b1 :
                         spread_up_r ? !(spread_step >= SSC_TOP) : (spread_step <= -SSC_TOP);

  // ==========================================================
  // output and state registers
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r     <= ST_SLEEP;
      drive_en_r  <= 1'b0;
      level_r     <= 1'b0;
      diag_r      <= 1'b0;
      mirror_r    <= 1'b0;
      toff_cnt_r  <= TOFF_RST;
      dis_prev_r  <= 1'b0;
      lvl_prev_r  <= 1'b0;
      slew_r      <= SLEW_RST;
      spread_r    <= SSC_RST;
      spread_up_r <= 1'b1;
    end
    else
    begin
      state_r     <= state_nxt;
      drive_en_r  <= next_active;
      level_r     <= level_nxt;
      diag_r      <= diag_nxt;
      mirror_r    <= mirror_nxt;
      toff_cnt_r  <= toff_nxt;
      dis_prev_r  <= dis_eff;
      lvl_prev_r  <= level_eff;
      slew_r      <= slew_nxt;
      spread_r    <= spread_nxt;
      spread_up_r <= spread_up_nxt;
    end
  end

  // ==========================================================
  // hardwired slew capture at start-up or wake
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      init_pending_r <= 1'b1;
      slew_hw_r      <= SLEW_RST;
    end
    else
    begin
      if (capture_slew)
        slew_hw_r <= slew_pin_lvl;
      init_pending_r <= state_nxt == ST_SLEEP;
    end
  end

  // ==========================================================
  // outputs
  assign prdata                = prdata_r;
  assign pready                = pready_r;
  assign pslverr               = pslverr_r;
  assign device_state          = state_r;
  assign bridge_drive_en       = drive_en_r;
  assign bridge_level          = level_r;
  assign offstate_diag_en      = diag_r;
  assign current_mirror_output = mirror_r;
  assign slew_select           = slew_r;
  assign spread_offset         = spread_r;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  sequence s_trip_hit;
    trip_start && !in_change;
  endsequence

  sequence s_held_low;
    (!level_r && drive_en_r)[*2];
  endsequence

  property p_sleep_hiz;
    !sleep_eff |=> state_r == ST_SLEEP && !drive_en_r && !mirror_r;
  endproperty
  a_sleep_hiz: assert property (p_sleep_hiz) else $error("sleep did not give hi-z");

  property p_standby;
    sleep_eff && powered && dis_eff |=> state_r == ST_STANDBY && !drive_en_r && diag_r == $past(level_eff);
  endproperty
  a_standby: assert property (p_standby) else $error("standby decode wrong");

  property p_active_follow;
    sleep_eff && powered && !dis_eff && toff_nxt == TOFF_RST |=> drive_en_r && level_r == $past(level_eff);
  endproperty
  a_active_follow: assert property (p_active_follow) else $error("active output not following level");

  property p_trip_low;
    s_trip_hit ##1 !in_change ##0 (sleep_eff && powered && !dis_eff) |->
      toff_cnt_r == 10'(TOFF_CYC) ##0 s_held_low ##0 toff_cnt_r == 10'(TOFF_CYC - 1);
  endproperty
  a_trip_low: assert property (p_trip_low) else $error("trip did not force low off-time");

  property p_ext_sleep;
    ext_mode |-> sleep_eff;
  endproperty
  a_ext_sleep: assert property (p_ext_sleep) else $error("external supply variant slept on pin");

  property p_por;
    ext_mode && !pin_s.logic_supply_ok |=> state_r == ST_SLEEP && !drive_en_r;
  endproperty
  a_por: assert property (p_por) else $error("decoded below supply threshold");

  property p_locked;
    !unlocked_r |-> dis_eff == pin_s.output_disable && level_eff == pin_s.drive_level;
  endproperty
  a_locked: assert property (p_locked) else $error("register bits acted while locked");

  property p_or_combine;
    use_regs && !sel_dis |-> dis_eff == (pin_s.output_disable || reg_output_disable);
  endproperty
  a_or_combine: assert property (p_or_combine) else $error("or combine wrong");

  property p_and_combine;
    use_regs && sel_lvl |-> level_eff == (pin_s.drive_level && reg_drive_level);
  endproperty
  a_and_combine: assert property (p_and_combine) else $error("and combine wrong");

  property p_sleep_pin_only;
    !ext_mode && !pin_s.sleep_request_low |=> state_r == ST_SLEEP;
  endproperty
  a_sleep_pin_only: assert property (p_sleep_pin_only) else $error("sleep pin overridden");

  property p_slew_range;
    !pin_s.serial_variant && $stable(pin_s.serial_variant) |=> slew_select <= SLEW_PIN_MAX;
  endproperty
  a_slew_range: assert property (p_slew_range) else $error("hardwired slew out of six levels");

  property p_slew_latched;
    !init_pending_r && !capture_slew |=> slew_hw_r == $past(slew_hw_r);
  endproperty
  a_slew_latched: assert property (p_slew_latched) else $error("slew pin change not ignored");

  property p_slew_serial;
    wr_shape && pin_s.serial_variant ##1 pin_s.serial_variant |=> slew_select == $past(pwdata[2:0], 2);
  endproperty
  a_slew_serial: assert property (p_slew_serial) else $error("serial slew write not applied");

  property p_spread;
    spread_r <= SSC_TOP && spread_r >= -SSC_TOP && (!$past(spread_on) -> spread_r == SSC_RST);
  endproperty
  a_spread: assert property (p_spread) else $error("spread offset out of range");

  property p_mirror;
    mirror_r |-> drive_en_r && level_r && $past(pin_s.high_side_on);
  endproperty
  a_mirror: assert property (p_mirror) else $error("mirror active without high side driving");

endmodule

// ===== controller_pins.sv
// external controller model that drives the device pins
`timescale 1ns/1ns
module controller_pins
  import half_bridge_pkg::*;
(
  // clock and reset
  input  wire logic    clock,
  input  wire logic    rstn,
  // requested pin levels
  input  wire pin_in_t want,
  input  wire logic    level_float,
  // device pins
  output pin_in_t      pins
);
  pin_in_t pins_nxt;

  // ==========================================================
  // a floating level pin reads low through its pull-down
  always_comb
  begin
    pins_nxt = want;
    if (level_float)
      pins_nxt.drive_level = 1'b0;
  end

  // ==========================================================
  // pin drive, changed just after the clock edge
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      pins <= '0;
    else
      pins <= pins_nxt;
  end
endmodule

// ===== test_half_bridge_input_control.sv
// self-checking testbench for the half-bridge input control block
`timescale 1ns/1ns
module test_half_bridge_input_control
  import half_bridge_pkg::*;
;
  logic               clock, rstn, psel, penable, pwrite, pready, pslverr, lvl_flt;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata, rd;
  logic               er, drv_en, drv_lvl, diag_en, mirror;
  pin_in_t            want, pins;
  dev_state_t         device_state;
  logic [2:0]         slew_select;
  logic signed [5:0]  spread_offset, mn, mx;
  logic [5:0]         r;
  int                 err_total, tests_run, seed, cycles;

  half_bridge_input_control u_dut (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pins(pins), .device_state(device_state), .bridge_drive_en(drv_en),
    .bridge_level(drv_lvl), .offstate_diag_en(diag_en), .current_mirror_output(mirror),
    .slew_select(slew_select), .spread_offset(spread_offset));
  controller_pins u_ctrl (.clock(clock), .rstn(rstn), .want(want), .level_float(lvl_flt), .pins(pins));

  // ==========================================================
  // checking and expectations
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  function automatic logic [5:0] exp_out(input logic s, input logic d, input logic l);
    if (!s)
      return {ST_SLEEP, 3'b000};
    if (d)
      return {ST_STANDBY, 2'b00, l};
    return {ST_ACTIVE, 1'b1, l, 1'b0};
  endfunction

  function automatic logic comb(input logic sel, input logic p, input logic b);
    return sel ? (p & b) : (p | b);
  endfunction

  task automatic check_out(input logic s, input logic d, input logic l);
    check({26'h0, device_state, drv_en, drv_lvl, diag_en}, {26'h0, exp_out(s, d, l)});
  endtask

  // ==========================================================
  // apb master and pin driver
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    check(n, 32'd1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic drive(input logic s, input logic d, input logic l);
    @(posedge clock);
    want.sleep_request_low <= s;
    want.output_disable    <= d;
    want.drive_level       <= l;
    repeat (6) @(posedge clock);
  endtask

  // ==========================================================
  // clock, reset and timeout
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      err_total++;
      complete_run();
    end
  end

  // ==========================================================
  // scenarios
  initial
  begin
    seed = 51;
    err_total = 0;
    tests_run = 0;
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    want = '0;
    lvl_flt = 1'b0;
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      apb(1'b0, 8'(4 * k), 32'h0);
      check(rd, 32'h0);
      check({31'h0, er}, 32'h0);
    end
    apb(1'b0, 8'h40, 32'h0);
    check({31'h0, er}, 32'h1);
    want.slew_setting_pin <= 3'h3;
    for (int i = 0; i < 24; i++)
    begin
      r = (i < 8) ? i[5:0] : 6'($random(seed));
      drive(r[2], r[1], r[0]);
      check_out(r[2], r[1], r[0]);
    end
    drive(1'b1, 1'b0, 1'b0);
    want.slew_setting_pin <= 3'h6;
    drive(1'b1, 1'b0, 1'b0);
    check({29'h0, slew_select}, 32'h3);
    drive(1'b0, 1'b0, 1'b0);
    drive(1'b1, 1'b0, 1'b0);
    check({29'h0, slew_select}, {29'h0, SLEW_PIN_MAX});
    want.trip_pin_enable <= 1'b1;
    want.high_side_on    <= 1'b1;
    drive(1'b1, 1'b0, 1'b1);
    check({31'h0, mirror}, 32'h1);
    want.trip_compare <= 1'b1;
    @(posedge clock);
    want.trip_compare <= 1'b0;
    repeat (8) @(posedge clock);
    check({31'h0, drv_lvl}, 32'h0);
    repeat (TOFF_CYC - 60) @(posedge clock);
    check({31'h0, drv_lvl}, 32'h0);
    repeat (100) @(posedge clock);
    check({31'h0, drv_lvl}, 32'h1);
    want.high_side_on <= 1'b0;
    drive(1'b1, 1'b0, 1'b1);
    check({31'h0, mirror}, 32'h0);
    want.serial_variant <= 1'b1;
    apb(1'b1, SHAPING_OFS, 32'h7);
    repeat (3) @(posedge clock);
    check({29'h0, slew_select}, 32'h7);
    apb(1'b1, SHAPING_OFS, 32'hf);
    mn = 6'sh00;
    mx = 6'sh00;
    repeat (40)
    begin
      @(posedge clock);
      mn = (spread_offset < mn) ? spread_offset : mn;
      mx = (spread_offset > mx) ? spread_offset : mx;
    end
    check({26'h0, mx}, 32'd12);
    check({26'h0, mn}, {26'h0, 6'sh34});
    apb(1'b1, SHAPING_OFS, 32'h0);
    apb(1'b1, PIN_CTL_OFS, 32'h3);
    drive(1'b1, 1'b0, 1'b0);
    check_out(1'b1, 1'b0, 1'b0);
    apb(1'b1, CMD_OFS, {24'h0, UNLOCK_KEY});
    for (int i = 0; i < 16; i++)
    begin
      r = (i == 0) ? 6'b100101 : (i == 1) ? 6'b001000 : 6'($random(seed));
      lvl_flt <= (i == 1);
      apb(1'b1, COMBINE_OFS, {30'h0, r[1:0]});
      apb(1'b1, PIN_CTL_OFS, {30'h0, r[3:2]});
      drive(1'b1, r[4], r[5]);
      check_out(1'b1, comb(r[0], r[4], r[2]), comb(r[1], r[5], r[3]));
    end
    lvl_flt <= 1'b0;
    drive(1'b0, 1'b0, 1'b1);
    check_out(1'b0, 1'b0, 1'b1);
    apb(1'b1, PIN_CTL_OFS, 32'h0);
    want.ext_logic_supply <= 1'b1;
    want.logic_supply_ok  <= 1'b1;
    drive(1'b0, 1'b0, 1'b0);
    check_out(1'b1, 1'b0, 1'b0);
    want.logic_supply_ok <= 1'b0;
    drive(1'b0, 1'b0, 1'b0);
    check_out(1'b0, 1'b0, 1'b0);
    complete_run();
  end
endmodule
